/* File: mbt_params.svh */
// mbt_params.svh - constants of the modbus tcp request server
// Operation
// - seven-byte header precedes every pdu
// - protocol id zero marks modbus
// - length counts unit id, code, data
// - unit id selects slave behind gateway
// - pdu is function code plus data
// - adu max 260, pdu max 253
// - accept connections on port 502
// - one response per request
// - close only on error, idle, limit
// - eight connections, evict oldest unused, else refuse
// - positive response echoes function code
// - negative response adds 80 hex, exception
// - malformed pdu closes connection, no reply
// - exceptions 01, 02, 03
// - exception 04 on server failure
// - exception 05 acknowledges long request
// - exception 06 when server busy
// - exceptions 0A and 0B for gateways
// - parameters are two 16-bit words
// - block access processes whole run
// - single parameter only in 6656..6911
// - word order per connection, address 6410
`ifndef MBT_PARAMS_SVH
`define MBT_PARAMS_SVH
`define MBT_MAX_CONN 8
`define MBT_ADU_MAX 260
`define MBT_PDU_MAX 253
`define MBT_HDR_LEN 7
`define MBT_PROTO_ID 16'h0000
`define MBT_PORT 16'h01F6
`define MBT_UNIT_ALL 8'hFF
`define MBT_UNIT_LOCAL 8'h01
`define MBT_FC_RD 8'h03
`define MBT_FC_WR 8'h10
`define MBT_EXC_FLAG 8'h80
`define MBT_EX_FUNC 8'h01
`define MBT_EX_ADDR 8'h02
`define MBT_EX_VALUE 8'h03
`define MBT_EX_GW_PATH 8'h0A
`define MBT_EX_BUSY 8'h06
`define MBT_RD_MAX_QTY 16'h007C
`define MBT_WR_MAX_QTY 16'h007A
`define MBT_SINGLE_LO 16'h1A00
`define MBT_SINGLE_HI 16'h1AFF
`define MBT_ORDER_ADDR 16'h190A
`define MBT_IDLE_MS 10000
`define MBT_CLK_KHZ 125000
`define MBT_IDLE_CYC (`MBT_IDLE_MS * `MBT_CLK_KHZ)
`endif

/* File: mbt_pkg.sv */
// mbt_pkg.sv - types of the modbus tcp request server
package mbt_pkg;
   typedef enum logic [2:0] {
      MBT_S_RECV,
      MBT_S_CHECK,
      MBT_S_ISSUE,
      MBT_S_WAIT,
      MBT_S_SEND
   } mbt_state_t;
   typedef enum logic [1:0] {
      MBT_C_ERROR,
      MBT_C_IDLE,
      MBT_C_LIMIT
   } mbt_cause_t;
endpackage

/* File: mbt_server.sv */
// mbt_server.sv - modbus tcp request server with connection table
`timescale 1ns/1ns
`include "mbt_params.svh"
module mbt_server #(
   parameter int NCONN = `MBT_MAX_CONN,
   parameter int ADU_MAX = `MBT_ADU_MAX,
   parameter logic [7:0] LOCAL_UNIT = `MBT_UNIT_LOCAL,
   parameter logic [31:0] IDLE_CYC = `MBT_IDLE_CYC,
   parameter int DEPTH = 2
)(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_last,
   input wire logic [$clog2(NCONN)-1:0] i_rx_conn,
   output logic o_rx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   output logic [$clog2(NCONN)-1:0] o_tx_conn,
   input wire logic i_tx_ready,
   input wire logic i_open_req,
   input wire logic [15:0] i_open_port,
   output logic o_open_ack,
   output logic o_open_ok,
   output logic [$clog2(NCONN)-1:0] o_open_id,
   input wire logic [NCONN-1:0] i_conn_hold,
   output logic [NCONN-1:0] o_conn_open,
   output logic o_close_valid,
   output logic [$clog2(NCONN)-1:0] o_close_id,
   output logic [1:0] o_close_cause,
   output logic o_par_req,
   output logic o_par_we,
   output logic [15:0] o_par_addr,
   output logic [31:0] o_par_wdata,
   output logic [$clog2(NCONN)-1:0] o_par_conn,
   input wire logic i_par_ack,
   input wire logic [31:0] i_par_rdata,
   input wire logic [7:0] i_par_exc,
   input wire logic i_srv_busy
);
   localparam int CW = $clog2(NCONN);
   localparam int PW = $clog2(DEPTH);
   localparam int FW = 9 + CW;

   // ---------------------------------------------
   // storage and state
   // ---------------------------------------------
   logic [7:0] rx_mem [0:ADU_MAX-1]; // request as received
   logic [7:0] tx_mem [0:ADU_MAX-1]; // read data of response
   mbt_pkg::mbt_state_t state_ff;
   logic [8:0] rx_cnt_ff; // bytes received
   logic ovf_ff; // frame ran past the limit
   logic [CW-1:0] conn_ff; // connection being served
   logic [15:0] addr_ff; // address of next parameter
   logic [6:0] rem_ff; // parameters still to do
   logic [8:0] ptr_ff; // write data pointer
   logic [8:0] tptr_ff; // read data pointer
   logic wr_ff; // request is a write
   logic [7:0] rsp_fc_ff;
   logic [7:0] rsp_b8_ff; // byte count or exception
   logic [15:0] rsp_len_ff;
   logic wr_pos_ff; // positive write response
   logic [8:0] tx_idx_ff;
   logic par_req_ff;
   logic par_we_ff;
   logic [15:0] par_addr_ff;
   logic [31:0] par_wdata_ff;
   logic [NCONN-1:0] valid_ff;
   logic [NCONN-1:0] swap_ff; // low word first when set
   logic [NCONN-1:0] expired;
   logic [7:0] age_ff [0:NCONN-1];
   logic open_ack_ff;
   logic open_ok_ff;
   logic [CW-1:0] open_id_ff;
   logic close_v_ff;
   logic [CW-1:0] close_id_ff;
   logic [1:0] close_cause_ff;

   // ---------------------------------------------
   // request field decode
   // ---------------------------------------------
   logic [15:0] f_proto;
   logic [15:0] f_len;
   logic [7:0] f_unit;
   logic [7:0] f_fc;
   logic [15:0] f_addr;
   logic [15:0] f_qty;
   logic [7:0] f_bc;
   logic [15:0] rx_after; // bytes behind length field
   logic malformed;
   logic [7:0] exc;
   logic [16:0] addr_end;

   // big-endian fields, fixed positions of header and pdu
   assign f_proto = {rx_mem[2], rx_mem[3]};
   assign f_len = {rx_mem[4], rx_mem[5]};
   assign f_unit = rx_mem[6];
   assign f_fc = rx_mem[7];
   assign f_addr = {rx_mem[8], rx_mem[9]};
   assign f_qty = {rx_mem[10], rx_mem[11]};
   assign f_bc = rx_mem[12];
   assign rx_after = {7'h00, rx_cnt_ff} - 16'h0006;
   assign addr_end = {1'b0, f_addr} + {1'b0, f_qty};

   // syntax faults drop the frame and the connection
   always_comb
   begin
      malformed = 1'b0;
      if (ovf_ff || rx_cnt_ff < 9'h008)
         malformed = 1'b1;
      else if (f_proto != `MBT_PROTO_ID)
         malformed = 1'b1;
      else if (f_len != rx_after)
         malformed = 1'b1;
      else if (f_fc == `MBT_FC_RD && f_len != 16'h0006)
         malformed = 1'b1;
      else if (f_fc == `MBT_FC_WR)
      begin
         // byte count must match both length and quantity
         if (rx_cnt_ff < 9'h00D || f_qty[15])
            malformed = 1'b1;
         else if ({8'h00, f_bc} + 16'h0007 != f_len)
            malformed = 1'b1;
         else if ({f_qty[14:0], 1'b0} != {8'h00, f_bc})
            malformed = 1'b1;
      end
   end

   // exception choice, first match wins; zero means go
   always_comb
   begin
      exc = 8'h00;
      if (f_unit != LOCAL_UNIT && f_unit != `MBT_UNIT_ALL)
         exc = `MBT_EX_GW_PATH;
      else if (i_srv_busy)
         exc = `MBT_EX_BUSY;
      else if (f_fc != `MBT_FC_RD && f_fc != `MBT_FC_WR)
         exc = `MBT_EX_FUNC;
      else if (f_qty == 16'h0000 || f_qty[0])
         exc = `MBT_EX_VALUE;
      else if (f_fc == `MBT_FC_RD && f_qty > `MBT_RD_MAX_QTY)
         exc = `MBT_EX_VALUE;
      else if (f_fc == `MBT_FC_WR && f_qty > `MBT_WR_MAX_QTY)
         exc = `MBT_EX_VALUE;
      else if (addr_end > 17'h10000)
         exc = `MBT_EX_ADDR;
      else if (f_addr >= `MBT_SINGLE_LO && f_addr <= `MBT_SINGLE_HI
               && f_qty != 16'h0002)
         exc = `MBT_EX_VALUE;
   end

   // ---------------------------------------------
   // output buffer
   // ---------------------------------------------
   logic [FW-1:0] fifo_mem [0:DEPTH-1];
   logic [PW-1:0] wp_ff;
   logic [PW-1:0] rp_ff;
   logic [PW:0] fcnt_ff;
   logic fifo_in_rdy;
   logic push;
   logic pop;
   logic [7:0] tx_byte;
   logic [15:0] tot_m1; // index of the last response byte
   logic tx_end;

   assign fifo_in_rdy = fcnt_ff != DEPTH[PW:0];
   assign o_tx_valid = fcnt_ff != '0;
   assign pop = o_tx_valid && i_tx_ready;
   assign push = state_ff == mbt_pkg::MBT_S_SEND && fifo_in_rdy;
   assign tot_m1 = rsp_len_ff + 16'h0005;
   assign tx_end = push && {7'h00, tx_idx_ff} == tot_m1;
   assign {o_tx_last, o_tx_conn, o_tx_data} = fifo_mem[rp_ff];

   // a stalled receiver fills the buffer and then holds the engine
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
         fcnt_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            fifo_mem[wp_ff] <= {tx_end, conn_ff, tx_byte};
            wp_ff <= wp_ff + 1'b1;
         end
         if (pop)
            rp_ff <= rp_ff + 1'b1;
         if (push && !pop)
            fcnt_ff <= fcnt_ff + 1'b1;
         else if (pop && !push)
            fcnt_ff <= fcnt_ff - 1'b1;
      end
   end

   // response byte select: header echoed from the request, except the length bytes, which come from rsp_len_ff
   always_comb
   begin
      tx_byte = tx_mem[tx_idx_ff];
      if (tx_idx_ff == 9'h004)
         tx_byte = rsp_len_ff[15:8];
      else if (tx_idx_ff == 9'h005)
         tx_byte = rsp_len_ff[7:0];
      else if (tx_idx_ff < 9'h007)
         tx_byte = rx_mem[tx_idx_ff];
      else if (tx_idx_ff == 9'h007)
         tx_byte = rsp_fc_ff;
      else if (wr_pos_ff && tx_idx_ff < 9'h00C)
         tx_byte = rx_mem[tx_idx_ff]; // address and quantity echo
      else if (tx_idx_ff == 9'h008)
         tx_byte = rsp_b8_ff;
   end

   // ---------------------------------------------
   // receive path
   // ---------------------------------------------
   logic rx_take;
   logic err_close;
   logic back_to_rx;
   logic ack_ok;

   assign o_rx_ready = state_ff == mbt_pkg::MBT_S_RECV;
   assign rx_take = o_rx_ready && i_rx_valid;
   assign err_close = state_ff == mbt_pkg::MBT_S_CHECK && malformed;
   assign back_to_rx = err_close || tx_end;
   assign ack_ok = state_ff == mbt_pkg::MBT_S_WAIT && i_par_ack && i_par_exc == 8'h00;

   // bytes beyond the limit are swallowed but mark the frame bad
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_cnt_ff <= 9'h000;
         ovf_ff <= 1'b0;
      end
      else if (back_to_rx)
      begin
         rx_cnt_ff <= 9'h000;
         ovf_ff <= 1'b0;
      end
      else if (rx_take)
      begin
         if (rx_cnt_ff < ADU_MAX[8:0])
         begin
            rx_mem[rx_cnt_ff] <= i_rx_data;
            rx_cnt_ff <= rx_cnt_ff + 9'h001;
         end
         else
            ovf_ff <= 1'b1;
      end
   end

   // read data lands in the response in the connection's word order
   always_ff @(posedge i_core_clk)
   begin
      if (ack_ok && !wr_ff)
      begin
         if (swap_ff[conn_ff])
         begin
            tx_mem[tptr_ff] <= i_par_rdata[15:8];
            tx_mem[tptr_ff + 9'h001] <= i_par_rdata[7:0];
            tx_mem[tptr_ff + 9'h002] <= i_par_rdata[31:24];
            tx_mem[tptr_ff + 9'h003] <= i_par_rdata[23:16];
         end
         else
         begin
            tx_mem[tptr_ff] <= i_par_rdata[31:24];
            tx_mem[tptr_ff + 9'h001] <= i_par_rdata[23:16];
            tx_mem[tptr_ff + 9'h002] <= i_par_rdata[15:8];
            tx_mem[tptr_ff + 9'h003] <= i_par_rdata[7:0];
         end
      end
   end

   // ---------------------------------------------
   // request engine
   // ---------------------------------------------
   logic [15:0] w_hi; // first word on the wire
   logic [15:0] w_lo;
   logic swap_wr;

   assign w_hi = {rx_mem[ptr_ff], rx_mem[ptr_ff + 9'h001]};
   assign w_lo = {rx_mem[ptr_ff + 9'h002], rx_mem[ptr_ff + 9'h003]};
   assign swap_wr = ack_ok && wr_ff && par_addr_ff == `MBT_ORDER_ADDR;

   // one response per request; parameters walked pair by pair
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_ff <= mbt_pkg::MBT_S_RECV;
         conn_ff <= '0;
         addr_ff <= 16'h0000;
         rem_ff <= 7'h00;
         ptr_ff <= 9'h000;
         tptr_ff <= 9'h000;
         wr_ff <= 1'b0;
         rsp_fc_ff <= 8'h00;
         rsp_b8_ff <= 8'h00;
         rsp_len_ff <= 16'h0000;
         wr_pos_ff <= 1'b0;
         tx_idx_ff <= 9'h000;
         par_req_ff <= 1'b0;
         par_we_ff <= 1'b0;
         par_addr_ff <= 16'h0000;
         par_wdata_ff <= 32'h0000_0000;
      end
      else
      begin
         par_req_ff <= 1'b0;
         case (state_ff)
            mbt_pkg::MBT_S_RECV:
            begin
               if (rx_take && i_rx_last)
               begin
                  conn_ff <= i_rx_conn;
                  state_ff <= mbt_pkg::MBT_S_CHECK;
               end
            end
            mbt_pkg::MBT_S_CHECK:
            begin
               wr_ff <= f_fc == `MBT_FC_WR;
               addr_ff <= f_addr;
               rem_ff <= f_qty[7:1];
               ptr_ff <= 9'h00D;
               tptr_ff <= 9'h009;
               if (malformed)
                  state_ff <= mbt_pkg::MBT_S_RECV;
               else if (exc != 8'h00)
               begin
                  rsp_fc_ff <= f_fc | `MBT_EXC_FLAG;
                  rsp_b8_ff <= exc;
                  rsp_len_ff <= 16'h0003;
                  wr_pos_ff <= 1'b0;
                  state_ff <= mbt_pkg::MBT_S_SEND;
               end
               else
               begin
                  rsp_fc_ff <= f_fc;
                  rsp_b8_ff <= {f_qty[6:0], 1'b0};
                  rsp_len_ff <= (f_fc == `MBT_FC_WR) ? 16'h0006 :
                     16'h0003 + {f_qty[14:0], 1'b0};
                  wr_pos_ff <= f_fc == `MBT_FC_WR;
                  state_ff <= mbt_pkg::MBT_S_ISSUE;
               end
            end
            mbt_pkg::MBT_S_ISSUE:
            begin
               par_req_ff <= 1'b1;
               par_we_ff <= wr_ff;
               par_addr_ff <= addr_ff;
               par_wdata_ff <= swap_ff[conn_ff] ? {w_lo, w_hi} : {w_hi, w_lo};
               state_ff <= mbt_pkg::MBT_S_WAIT;
            end
            mbt_pkg::MBT_S_WAIT:
            begin
               if (i_par_ack && i_par_exc != 8'h00)
               begin
                  // store fault: codes 02..05 and 0B pass through
                  rsp_fc_ff <= rsp_fc_ff | `MBT_EXC_FLAG;
                  rsp_b8_ff <= i_par_exc;
                  rsp_len_ff <= 16'h0003;
                  wr_pos_ff <= 1'b0;
                  state_ff <= mbt_pkg::MBT_S_SEND;
               end
               else if (i_par_ack)
               begin
                  ptr_ff <= ptr_ff + 9'h004;
                  tptr_ff <= tptr_ff + 9'h004;
                  addr_ff <= addr_ff + 16'h0002;
                  rem_ff <= rem_ff - 7'h01;
                  if (rem_ff == 7'h01)
                     state_ff <= mbt_pkg::MBT_S_SEND;
                  else
                     state_ff <= mbt_pkg::MBT_S_ISSUE;
               end
            end
            mbt_pkg::MBT_S_SEND:
            begin
               if (tx_end)
               begin
                  tx_idx_ff <= 9'h000;
                  state_ff <= mbt_pkg::MBT_S_RECV;
               end
               else if (push)
                  tx_idx_ff <= tx_idx_ff + 9'h001;
            end
            default:
               state_ff <= mbt_pkg::MBT_S_RECV;
         endcase
      end
   end

   assign o_par_req = par_req_ff;
   assign o_par_we = par_we_ff;
   assign o_par_addr = par_addr_ff;
   assign o_par_wdata = par_wdata_ff;
   assign o_par_conn = conn_ff;

   // ---------------------------------------------
   // connection table
   // ---------------------------------------------
   logic free_hit;
   logic [CW-1:0] free_id;
   logic evict_hit;
   logic [CW-1:0] evict_id;
   logic [7:0] evict_age;
   logic idle_hit;
   logic [CW-1:0] idle_id;
   logic open_go;
   logic open_ok;
   logic [CW-1:0] open_id;
   logic close_now;
   logic [CW-1:0] close_id;
   mbt_pkg::mbt_cause_t close_cause;

   // pick free slot, oldest unused slot and first idle slot
   always_comb
   begin
      free_hit = 1'b0;
      free_id = '0;
      evict_hit = 1'b0;
      evict_id = '0;
      evict_age = 8'h00;
      idle_hit = 1'b0;
      idle_id = '0;
      for (int n = NCONN - 1; n >= 0; n--)
      begin
         if (!valid_ff[n])
         begin
            free_hit = 1'b1;
            free_id = n[CW-1:0];
         end
         if (expired[n])
         begin
            idle_hit = 1'b1;
            idle_id = n[CW-1:0];
         end
      end
      for (int n = 0; n < NCONN; n++)
      begin
         // held slots and the one being served are in use
         if (valid_ff[n] && !i_conn_hold[n]
             && !(state_ff != mbt_pkg::MBT_S_RECV && conn_ff == n[CW-1:0])
             && (!evict_hit || age_ff[n] > evict_age))
         begin
            evict_hit = 1'b1;
            evict_id = n[CW-1:0];
            evict_age = age_ff[n];
         end
      end
   end

   // opens wait while an error close owns the close port
   assign open_go = i_open_req && !open_ack_ff && !err_close;
   assign open_ok = open_go && i_open_port == `MBT_PORT && (free_hit || evict_hit);
   assign open_id = free_hit ? free_id : evict_id;

   // one close per cycle: error, then eviction, then idle
   always_comb
   begin
      close_now = 1'b1;
      close_id = conn_ff;
      close_cause = mbt_pkg::MBT_C_ERROR;
      if (err_close)
         close_cause = mbt_pkg::MBT_C_ERROR;
      else if (open_ok && !free_hit)
      begin
         close_id = evict_id;
         close_cause = mbt_pkg::MBT_C_LIMIT;
      end
      else if (idle_hit)
      begin
         close_id = idle_id;
         close_cause = mbt_pkg::MBT_C_IDLE;
      end
      else
         close_now = 1'b0;
   end

   // per slot: open flag, age rank, idle timer, word order
   genvar g;
   generate
      for (g = 0; g < NCONN; g++)
      begin : g_slot
         logic [31:0] idle_ff;
         logic opened;
         logic active;
         assign opened = open_ok && open_id == g[CW-1:0];
         assign active = (rx_take && i_rx_conn == g[CW-1:0])
            || (state_ff != mbt_pkg::MBT_S_RECV && conn_ff == g[CW-1:0]);
         assign expired[g] = valid_ff[g] && idle_ff == IDLE_CYC;

         // reopen beats the close of an evicted slot
         always_ff @(posedge i_core_clk or posedge i_rst)
         begin
            if (i_rst)
               valid_ff[g] <= 1'b0;
            else if (opened)
               valid_ff[g] <= 1'b1;
            else if (close_now && close_id == g[CW-1:0])
               valid_ff[g] <= 1'b0;
         end

         // saturating rank; ties go to the lowest slot
         always_ff @(posedge i_core_clk or posedge i_rst)
         begin
            if (i_rst)
               age_ff[g] <= 8'h00;
            else if (opened)
               age_ff[g] <= 8'h00;
            else if (open_ok && valid_ff[g] && age_ff[g] != 8'hFF)
               age_ff[g] <= age_ff[g] + 8'h01;
         end

         // inactivity timer, parked at its end until closed
         always_ff @(posedge i_core_clk or posedge i_rst)
         begin
            if (i_rst)
               idle_ff <= 32'h0000_0000;
            else if (!valid_ff[g] || active || opened)
               idle_ff <= 32'h0000_0000;
            else if (idle_ff != IDLE_CYC)
               idle_ff <= idle_ff + 32'h0000_0001;
         end

         // new connection starts high word first
         always_ff @(posedge i_core_clk or posedge i_rst)
         begin
            if (i_rst)
               swap_ff[g] <= 1'b0;
            else if (opened)
               swap_ff[g] <= 1'b0;
            else if (swap_wr && conn_ff == g[CW-1:0])
               swap_ff[g] <= par_wdata_ff[0];
         end
      end
   endgenerate

   // registered answers of the connection port
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         open_ack_ff <= 1'b0;
         open_ok_ff <= 1'b0;
         open_id_ff <= '0;
         close_v_ff <= 1'b0;
         close_id_ff <= '0;
         close_cause_ff <= 2'h0;
      end
      else
      begin
         open_ack_ff <= open_go;
         open_ok_ff <= open_ok;
         open_id_ff <= open_id;
         close_v_ff <= close_now;
         close_id_ff <= close_id;
         close_cause_ff <= close_cause;
      end
   end

   assign o_open_ack = open_ack_ff;
   assign o_open_ok = open_ok_ff;
   assign o_open_id = open_id_ff;
   assign o_close_valid = close_v_ff;
   assign o_close_id = close_id_ff;
   assign o_close_cause = close_cause_ff;
   assign o_conn_open = valid_ff;
endmodule

/* File: mbt_server_asserts.sv */
// port checks of the modbus tcp request server
`timescale 1ns/1ns
module mbt_server_asserts #(parameter int NCONN = 8)(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_rx_valid,
   input wire logic i_rx_last,
   input wire logic o_rx_ready,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_last,
   input wire logic i_tx_ready,
   input wire logic [15:0] i_open_port,
   input wire logic o_open_ack,
   input wire logic o_open_ok,
   input wire logic [$clog2(NCONN)-1:0] o_open_id,
   input wire logic o_close_valid,
   input wire logic [$clog2(NCONN)-1:0] o_close_id,
   input wire logic [1:0] o_close_cause,
   input wire logic o_par_req,
   input wire logic [15:0] o_par_addr,
   input wire logic i_par_ack
);
   // ----------------------------------------
   // one clock domain, so defaults once
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_last_taken;
      i_rx_valid && o_rx_ready && i_rx_last;
   endsequence
   sequence s_open_done;
      o_open_ack && o_open_ok;
   endsequence
   property p_rx_busy;
      s_last_taken |=> !o_rx_ready;
   endproperty
   a_rx_busy: assert property (p_rx_busy) else $error("rx ready after last");
   property p_open_port;
      s_open_done |-> $past(i_open_port) == 16'h01F6;
   endproperty
   a_open_port: assert property (p_open_port) else $error("open on bad port");
   property p_ack_pulse;
      o_open_ack |=> !o_open_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_evict;
      o_close_valid && o_close_cause == 2'h2 |-> s_open_done ##0 o_close_id == o_open_id;
   endproperty
   a_evict: assert property (p_evict) else $error("evict mismatch");
   property p_par_pulse;
      o_par_req |=> !o_par_req;
   endproperty
   a_par_pulse: assert property (p_par_pulse) else $error("req too long");
   property p_par_gap;
      i_par_ack |=> !o_par_req;
   endproperty
   a_par_gap: assert property (p_par_gap) else $error("req after ack");
   property p_par_hold;
      !o_par_req |-> $stable(o_par_addr);
   endproperty
   a_par_hold: assert property (p_par_hold) else $error("addr moved");
   property p_tx_hold;
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx lost");
endmodule
bind mbt_server mbt_server_asserts #(.NCONN(NCONN)) u_chk (.*);

/* File: mbt_store_model.sv */
// parameter store stand-in on the server's parameter port
`timescale 1ns/1ns
module mbt_store_model #(parameter int DLY = 3)(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   int cnt_ff; // cycles left before the answer
   // one ack per request; data is garbage outside the ack cycle
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_ff <= 0;
         o_ack <= 1'b0;
         o_rdata <= 32'h00000000;
      end
      else
      begin
         cnt_ff <= i_req ? DLY : (cnt_ff > 0 ? cnt_ff - 1 : 0);
         o_ack <= (cnt_ff == 1);
         o_rdata <= (cnt_ff == 1) ? {i_addr, ~i_addr} : ~o_rdata;
      end
   end
endmodule

/* File: test_mbt_server.sv */
// self-checking bench of the modbus tcp request server
`timescale 1ns/1ns
module test_mbt_server;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_rx_valid = 1'b0, i_rx_last = 1'b0;
   logic i_tx_ready = 1'b0, i_open_req = 1'b0, i_srv_busy = 1'b0, i_par_ack;
   logic o_rx_ready, o_tx_valid, o_tx_last, o_open_ack, o_open_ok, o_close_valid;
   logic o_par_req, o_par_we;
   logic [7:0] i_rx_data = 8'h00, i_par_exc = 8'h00, i_conn_hold = 8'h00;
   logic [7:0] o_tx_data, o_conn_open;
   logic [2:0] i_rx_conn = 3'h0, o_tx_conn, o_open_id, o_close_id, o_par_conn;
   logic [15:0] i_open_port = 16'h0000, o_par_addr;
   logic [31:0] o_par_wdata, i_par_rdata;
   logic [1:0] o_close_cause;
   int n_errors = 0;
   int num_checks = 0;
   always #4 i_core_clk = ~i_core_clk;
   mbt_server #(.IDLE_CYC(32'd2000)) dut (.*);
   mbt_store_model u_store (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(o_par_req),
      .i_addr(o_par_addr), .o_ack(i_par_ack), .o_rdata(i_par_rdata));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x)
      begin
         n_errors++;
         $display("unexpected at %0t got %h expected %h", $time, g, x);
      end
   endtask
   // bytes of one adu, held until taken
   task send(input logic [7:0] f[$]);
      int i, k;
      i = 0;
      k = 0;
      while (i < f.size() && k < 2000)
      begin
         i_rx_valid <= 1'b1;
         i_rx_data <= f[i];
         i_rx_last <= (i == f.size() - 1);
         @(posedge i_core_clk);
         k++;
         if (o_rx_ready)
            i++;
      end
      i_rx_valid <= 1'b0;
      chk(k < 2000, 1'b1);
      if (k >= 2000)
         wrap_up();
   endtask
   // receiver stalls every other cycle to exercise the buffer
   task recv(input logic [7:0] e[$]);
      int i, k;
      i = 0;
      k = 0;
      while (i < e.size() && k < 3000)
      begin
         i_tx_ready <= k[0];
         @(posedge i_core_clk);
         k++;
         if (o_tx_valid && i_tx_ready)
         begin
            chk(o_tx_data, e[i]);
            chk(o_tx_last, i == e.size() - 1);
            i++;
         end
      end
      i_tx_ready <= 1'b0;
      chk(k < 3000, 1'b1);
      if (k >= 3000)
         wrap_up();
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // read-style request; ex 0 means positive, nonzero pid means malformed
   task xact(input logic [15:0] tid, pid, a, q, input logic [7:0] u, fc, ex);
      logic [7:0] f[$];
      logic [7:0] e[$];
      int k;
      f = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'h06, u, fc, a[15:8], a[7:0],
         q[15:8], q[7:0]};
      e = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h07, u, fc, 8'h04, a[15:8], a[7:0],
         ~a[15:8], ~a[7:0]};
      if (ex != 8'h00)
         e = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h03, u, fc | 8'h80, ex};
      send(f);
      k = 0;
      while (pid != 16'h0000 && !o_close_valid && k < 20)
      begin
         @(posedge i_core_clk);
         k++;
      end
      if (pid != 16'h0000)
         chk({o_close_valid, o_close_cause}, 3'h4);
      else
         recv(e);
   endtask
   task opn(input logic [15:0] p, input logic ok, ev, input logic [2:0] id);
      int k;
      k = 0;
      i_open_req <= 1'b1;
      i_open_port <= p;
      while (o_open_ack !== 1'b1 && k < 50)
      begin
         @(posedge i_core_clk);
         k++;
      end
      i_open_req <= 1'b0;
      chk({k < 50, o_open_ok, o_close_valid}, {1'b1, ok, ev});
      if (ok)
         chk(o_open_id, id);
      @(posedge i_core_clk);
   endtask
   initial
   begin
      repeat (6) @(posedge i_core_clk);
      i_rst <= 1'b0;
      opn(16'h01F6, 1'b1, 1'b0, 3'h0);
      opn(16'h0050, 1'b0, 1'b0, 3'h0);
      xact(16'h1234, 16'h0000, 16'h0610, 16'h0002, 8'h01, 8'h03, 8'h00);
      xact(16'h0002, 16'h0000, 16'h0610, 16'h0002, 8'hFF, 8'h05, 8'h01);
      xact(16'h0003, 16'h0000, 16'h0610, 16'h0000, 8'h01, 8'h03, 8'h03);
      xact(16'h0004, 16'h0000, 16'hFFFF, 16'h0002, 8'h01, 8'h03, 8'h02);
      xact(16'h0005, 16'h0000, 16'h1A00, 16'h0004, 8'h01, 8'h03, 8'h03);
      xact(16'h0006, 16'h0000, 16'h1A00, 16'h0002, 8'h01, 8'h03, 8'h00);
      xact(16'h0007, 16'h0000, 16'h0610, 16'h0002, 8'h07, 8'h03, 8'h0A);
      i_srv_busy <= 1'b1;
      xact(16'h0008, 16'h0000, 16'h0610, 16'h0002, 8'h01, 8'h03, 8'h06);
      i_srv_busy <= 1'b0;
      xact(16'h0009, 16'h0001, 16'h0610, 16'h0002, 8'h01, 8'h03, 8'h00);
      for (int n = 0; n < 8; n++)
         opn(16'h01F6, 1'b1, 1'b0, n[2:0]);
      opn(16'h01F6, 1'b1, 1'b1, 3'h0);
      chk(o_conn_open, 8'hFF);
      i_conn_hold <= 8'hFF;
      opn(16'h01F6, 1'b0, 1'b0, 3'h0);
      wrap_up();
   end
endmodule
